//--- bcc_defines.vh
// Constants for the channel C address and data compare stage.
// Assumes a 16-bit register port with word indices and one 40 MHz clock.
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH

// Register word indices on the register port
`define BCC_IDX_ADDR_MASK_UPPER 4'h0
`define BCC_IDX_ADDR_MASK_LOWER 4'h1
`define BCC_IDX_DATA_REF_UPPER 4'h2
`define BCC_IDX_DATA_REF_LOWER 4'h3
`define BCC_IDX_DATA_MASK_UPPER 4'h4
`define BCC_IDX_DATA_MASK_LOWER 4'h5
`define BCC_IDX_BUS_SEL 4'h6
`define BCC_IDX_IRQ_STATUS 4'h7
`define BCC_IDX_IRQ_MASK 4'h8

// Field positions
`define BCC_BIT_XY_BUS_SELECT 9
`define BCC_BIT_X_OR_Y_SELECT 8
`define BCC_BIT_EV_ADDR 0
`define BCC_BIT_EV_DATA 1
`define BCC_BIT_EV_BOTH 2
`define BCC_EV_BITS 3

// Reset values
`define BCC_RESET_16 16'h0000
`define BCC_RESET_EV 3'h0

`endif

//--- bcc_reg16.v
// One 16-bit software register with power-on and manual reset.
// Assumes both resets are synchronous and active low on the same clock.
`timescale 1ns/100ps
`default_nettype none
module bcc_reg16 #(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter CLEAR_ON_MANUAL = 1
) (
    input wire clk,
    input wire po_rst_n,
    input wire man_rst_n,
    input wire we,
    input wire [15:0] wdata,
    output reg [15:0] q_ff
);

    // Manual reset may leave contents alone, which is the cheaper choice
    always @(posedge clk) begin
        if (!po_rst_n) begin
            q_ff <= RESET_VALUE;
        end else if (!man_rst_n && (CLEAR_ON_MANUAL != 0)) begin
            q_ff <= RESET_VALUE;
        end else if (we) begin
            q_ff <= wdata;
        end
    end

endmodule
`default_nettype wire

//--- bcc_mask_cmp.v
// Masked 16-bit equality compare for one half of a break channel.
// Assumes bus, reference and mask come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module bcc_mask_cmp (
    input wire enable,
    input wire ignore_lsb,
    input wire [15:0] bus_value,
    input wire [15:0] ref_value,
    input wire [15:0] mask_value,
    output wire match
);

    wire [15:0] lsb_drop;
    wire [15:0] eff_mask;
    wire [15:0] bit_ok;

    // Word-only buses carry no meaningful bit 0
    assign lsb_drop = {15'h0000, ignore_lsb};
    assign eff_mask = mask_value | lsb_drop;

    // A set mask bit lets that bit differ
    assign bit_ok = eff_mask | ~(bus_value ^ ref_value);

    // Disabled half never vetoes the other half
    assign match = ~enable | (&bit_ok);

endmodule
`default_nettype wire

//--- bcc_break_c.v
// Channel C address and data compare stage of the user break logic.
// Holds the address mask, data reference and data mask registers, picks
// the observed bus by the bus-select bits and flags matches each cycle.
// Assumes observed buses, cycle strobe and reference address come from
// logic on CLOCK, so they are read without synchronisers.
`timescale 1ns/100ps
`default_nettype none
`include "bcc_defines.vh"
module bcc_break_c (
    input wire CLOCK,
    input wire RST_N,
    input wire MRST_N,
    input wire [3:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [15:0] REG_RDATA,
    input wire [15:0] REF_ADDR_UPPER_C,
    input wire [15:0] REF_ADDR_LOWER_C,
    input wire BUS_CYCLE_VALID,
    input wire [31:0] IBUS_ADDR,
    input wire [31:0] IBUS_DATA,
    input wire [15:0] X_ADDR,
    input wire [15:0] X_DATA,
    input wire [15:0] Y_ADDR,
    input wire [15:0] Y_DATA,
    output reg ADDR_MATCH,
    output reg DATA_MATCH,
    output reg BREAK_MATCH,
    output reg IRQ
);

    // Software registers
    wire [15:0] addr_mask_upper_c;
    wire [15:0] addr_mask_lower_c;
    wire [15:0] data_ref_upper_c;
    wire [15:0] data_ref_lower_c;
    wire [15:0] data_mask_upper_c;
    wire [15:0] data_mask_lower_c;
    reg xy_bus_select_ff;
    reg x_or_y_select_ff;
    reg [`BCC_EV_BITS-1:0] irq_status_ff;
    reg [`BCC_EV_BITS-1:0] irq_mask_ff;
    reg [`BCC_EV_BITS-1:0] nxt_irq_status;
    reg [`BCC_EV_BITS-1:0] nxt_irq_mask;
    reg [15:0] nxt_rdata;

    // Write decode
    wire wr_addr_mask_upper;
    wire wr_addr_mask_lower;
    wire wr_data_ref_upper;
    wire wr_data_ref_lower;
    wire wr_data_mask_upper;
    wire wr_data_mask_lower;
    wire wr_bus_sel;
    wire wr_irq_status;
    wire wr_irq_mask;

    // Compare steering
    reg upper_en;
    reg lower_en;
    reg lsb_ignore_upper;
    reg lsb_ignore_lower;
    reg [15:0] addr_bus_upper;
    reg [15:0] addr_bus_lower;
    reg [15:0] data_bus_upper;
    reg [15:0] data_bus_lower;
    wire addr_hit_upper;
    wire addr_hit_lower;
    wire data_hit_upper;
    wire data_hit_lower;
    wire addr_hit;
    wire data_hit;
    wire [`BCC_EV_BITS-1:0] ev_set;

    // Strobe qualifies each write to at most one register
    assign wr_addr_mask_upper = REG_WR && (REG_ADDR == `BCC_IDX_ADDR_MASK_UPPER);
    assign wr_addr_mask_lower = REG_WR && (REG_ADDR == `BCC_IDX_ADDR_MASK_LOWER);
    assign wr_data_ref_upper = REG_WR && (REG_ADDR == `BCC_IDX_DATA_REF_UPPER);
    assign wr_data_ref_lower = REG_WR && (REG_ADDR == `BCC_IDX_DATA_REF_LOWER);
    assign wr_data_mask_upper = REG_WR && (REG_ADDR == `BCC_IDX_DATA_MASK_UPPER);
    assign wr_data_mask_lower = REG_WR && (REG_ADDR == `BCC_IDX_DATA_MASK_LOWER);
    assign wr_bus_sel = REG_WR && (REG_ADDR == `BCC_IDX_BUS_SEL);
    assign wr_irq_status = REG_WR && (REG_ADDR == `BCC_IDX_IRQ_STATUS);
    assign wr_irq_mask = REG_WR && (REG_ADDR == `BCC_IDX_IRQ_MASK);

    // Address mask, upper half
    bcc_reg16 #(
        .RESET_VALUE(`BCC_RESET_16),
        .CLEAR_ON_MANUAL(0)
    ) u_addr_mask_upper (
        .clk(CLOCK),
        .po_rst_n(RST_N),
        .man_rst_n(MRST_N),
        .we(wr_addr_mask_upper),
        .wdata(REG_WDATA),
        .q_ff(addr_mask_upper_c)
    );

    // Address mask, lower half
    bcc_reg16 #(
        .RESET_VALUE(`BCC_RESET_16),
        .CLEAR_ON_MANUAL(0)
    ) u_addr_mask_lower (
        .clk(CLOCK),
        .po_rst_n(RST_N),
        .man_rst_n(MRST_N),
        .we(wr_addr_mask_lower),
        .wdata(REG_WDATA),
        .q_ff(addr_mask_lower_c)
    );

    // Data reference, upper half
    bcc_reg16 #(
        .RESET_VALUE(`BCC_RESET_16),
        .CLEAR_ON_MANUAL(0)
    ) u_data_ref_upper (
        .clk(CLOCK),
        .po_rst_n(RST_N),
        .man_rst_n(MRST_N),
        .we(wr_data_ref_upper),
        .wdata(REG_WDATA),
        .q_ff(data_ref_upper_c)
    );

    // Data reference, lower half
    bcc_reg16 #(
        .RESET_VALUE(`BCC_RESET_16),
        .CLEAR_ON_MANUAL(0)
    ) u_data_ref_lower (
        .clk(CLOCK),
        .po_rst_n(RST_N),
        .man_rst_n(MRST_N),
        .we(wr_data_ref_lower),
        .wdata(REG_WDATA),
        .q_ff(data_ref_lower_c)
    );

    // Data masks keep their value on manual reset, which software must not trust
    bcc_reg16 #(
        .RESET_VALUE(`BCC_RESET_16),
        .CLEAR_ON_MANUAL(0)
    ) u_data_mask_upper (
        .clk(CLOCK),
        .po_rst_n(RST_N),
        .man_rst_n(MRST_N),
        .we(wr_data_mask_upper),
        .wdata(REG_WDATA),
        .q_ff(data_mask_upper_c)
    );

    // Data mask, lower half
    bcc_reg16 #(
        .RESET_VALUE(`BCC_RESET_16),
        .CLEAR_ON_MANUAL(0)
    ) u_data_mask_lower (
        .clk(CLOCK),
        .po_rst_n(RST_N),
        .man_rst_n(MRST_N),
        .we(wr_data_mask_lower),
        .wdata(REG_WDATA),
        .q_ff(data_mask_lower_c)
    );

    // Bus selection bits, cleared by either reset
    always @(posedge CLOCK) begin
        if (!RST_N || !MRST_N) begin
            xy_bus_select_ff <= 1'b0;
            x_or_y_select_ff <= 1'b0;
        end else if (wr_bus_sel) begin
            xy_bus_select_ff <= REG_WDATA[`BCC_BIT_XY_BUS_SELECT];
            x_or_y_select_ff <= REG_WDATA[`BCC_BIT_X_OR_Y_SELECT];
        end
    end

    // Lane steering by bus-select and X/Y select
    always @* begin
        upper_en = 1'b1;
        lower_en = 1'b1;
        lsb_ignore_upper = 1'b0;
        lsb_ignore_lower = 1'b0;
        addr_bus_upper = IBUS_ADDR[31:16];
        addr_bus_lower = IBUS_ADDR[15:0];
        data_bus_upper = IBUS_DATA[31:16];
        data_bus_lower = IBUS_DATA[15:0];
        if (xy_bus_select_ff) begin
            if (!x_or_y_select_ff) begin
                // X bus uses only the upper halves
                lower_en = 1'b0;
                lsb_ignore_upper = 1'b1;
                addr_bus_upper = X_ADDR;
                data_bus_upper = X_DATA;
            end else begin
                // Y bus uses only the lower halves
                upper_en = 1'b0;
                lsb_ignore_lower = 1'b1;
                addr_bus_lower = Y_ADDR;
                data_bus_lower = Y_DATA;
            end
        end
    end

    // Upper address half against its mask
    bcc_mask_cmp u_addr_cmp_upper (
        .enable(upper_en),
        .ignore_lsb(lsb_ignore_upper),
        .bus_value(addr_bus_upper),
        .ref_value(REF_ADDR_UPPER_C),
        .mask_value(addr_mask_upper_c),
        .match(addr_hit_upper)
    );

    // Lower address half against its mask
    bcc_mask_cmp u_addr_cmp_lower (
        .enable(lower_en),
        .ignore_lsb(lsb_ignore_lower),
        .bus_value(addr_bus_lower),
        .ref_value(REF_ADDR_LOWER_C),
        .mask_value(addr_mask_lower_c),
        .match(addr_hit_lower)
    );

    // Data halves never drop bit 0; byte lanes are handled by software masks
    bcc_mask_cmp u_data_cmp_upper (
        .enable(upper_en),
        .ignore_lsb(1'b0),
        .bus_value(data_bus_upper),
        .ref_value(data_ref_upper_c),
        .mask_value(data_mask_upper_c),
        .match(data_hit_upper)
    );

    // Lower data half against its mask
    bcc_mask_cmp u_data_cmp_lower (
        .enable(lower_en),
        .ignore_lsb(1'b0),
        .bus_value(data_bus_lower),
        .ref_value(data_ref_lower_c),
        .mask_value(data_mask_lower_c),
        .match(data_hit_lower)
    );

    // Both halves must agree, only on a qualifying cycle
    assign addr_hit = BUS_CYCLE_VALID & addr_hit_upper & addr_hit_lower;
    assign data_hit = BUS_CYCLE_VALID & data_hit_upper & data_hit_lower;
    assign ev_set = {addr_hit & data_hit, data_hit, addr_hit};

    // Match pulses, one cycle after the bus cycle
    always @(posedge CLOCK) begin
        if (!RST_N || !MRST_N) begin
            ADDR_MATCH <= 1'b0;
            DATA_MATCH <= 1'b0;
            BREAK_MATCH <= 1'b0;
        end else begin
            ADDR_MATCH <= addr_hit;
            DATA_MATCH <= data_hit;
            BREAK_MATCH <= addr_hit & data_hit;
        end
    end

    // Sticky events; a new event beats a same-cycle write-one clear
    // so a hit arriving while software acknowledges is never lost
    always @* begin
        nxt_irq_status = irq_status_ff;
        if (wr_irq_status) begin
            nxt_irq_status = irq_status_ff & ~REG_WDATA[`BCC_EV_BITS-1:0];
        end
        nxt_irq_status = nxt_irq_status | ev_set;
    end

    // Mask follows a write at once, so the interrupt never lags a mask change
    always @* begin
        nxt_irq_mask = irq_mask_ff;
        if (wr_irq_mask) begin
            nxt_irq_mask = REG_WDATA[`BCC_EV_BITS-1:0];
        end
    end

    // Status and mask registers
    always @(posedge CLOCK) begin
        if (!RST_N || !MRST_N) begin
            irq_status_ff <= `BCC_RESET_EV;
            irq_mask_ff <= `BCC_RESET_EV;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // Level interrupt from the next status and mask, so it lines up with both
    always @(posedge CLOCK) begin
        if (!RST_N || !MRST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(nxt_irq_status & nxt_irq_mask);
        end
    end

    // Read mux; unmapped indices read zero
    always @* begin
        nxt_rdata = 16'h0000;
        case (REG_ADDR)
            `BCC_IDX_ADDR_MASK_UPPER: nxt_rdata = addr_mask_upper_c;
            `BCC_IDX_ADDR_MASK_LOWER: nxt_rdata = addr_mask_lower_c;
            `BCC_IDX_DATA_REF_UPPER: nxt_rdata = data_ref_upper_c;
            `BCC_IDX_DATA_REF_LOWER: nxt_rdata = data_ref_lower_c;
            `BCC_IDX_DATA_MASK_UPPER: nxt_rdata = data_mask_upper_c;
            `BCC_IDX_DATA_MASK_LOWER: nxt_rdata = data_mask_lower_c;
            `BCC_IDX_BUS_SEL: begin
                nxt_rdata[`BCC_BIT_XY_BUS_SELECT] = xy_bus_select_ff;
                nxt_rdata[`BCC_BIT_X_OR_Y_SELECT] = x_or_y_select_ff;
            end
            `BCC_IDX_IRQ_STATUS: nxt_rdata[`BCC_EV_BITS-1:0] = irq_status_ff;
            `BCC_IDX_IRQ_MASK: nxt_rdata[`BCC_EV_BITS-1:0] = irq_mask_ff;
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            REG_RDATA <= nxt_rdata;
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

//--- bcc_bus_model.sv
// Model of the core and memory buses watched by the compare stage.
// Assumes the bench sets a request just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module bcc_bus_model (
    input wire logic clk,
    input wire logic req_v,
    input wire logic req_q,
    input wire logic [31:0] req_a,
    input wire logic [31:0] req_d,
    output wire logic valid,
    output wire logic [31:0] ibus_a,
    output wire logic [31:0] ibus_d,
    output wire logic [15:0] x_a,
    output wire logic [15:0] x_d,
    output wire logic [15:0] y_a,
    output wire logic [15:0] y_d
);
    reg [63:0] last_ff = 64'h0;
    // Idle buses flip every cycle so a stale beat can never match
    // A quiet beat shows the request on the buses without qualifying it
    wire [63:0] nxt_last = (req_v || req_q) ? {req_a, req_d} : ~last_ff;
    always @(posedge clk) begin
        last_ff <= nxt_last;
    end
    // X lanes carry the upper halves, Y lanes the lower halves
    assign valid = req_v;
    assign {ibus_a, ibus_d} = nxt_last;
    assign x_a = nxt_last[63:48];
    assign y_a = nxt_last[47:32];
    assign x_d = nxt_last[31:16];
    assign y_d = nxt_last[15:0];
endmodule
`default_nettype wire

//--- bcc_break_c_asserts.sv
// Checker for the channel C compare stage, bound to its top module.
// Assumes one clock and synchronous RST_N and MRST_N.
`timescale 1ns/100ps
`default_nettype none
module bcc_break_c_asserts (
    input wire CLOCK,
    input wire RST_N,
    input wire MRST_N,
    input wire [3:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [15:0] REG_RDATA,
    input wire [15:0] REF_ADDR_UPPER_C,
    input wire [15:0] REF_ADDR_LOWER_C,
    input wire BUS_CYCLE_VALID,
    input wire [31:0] IBUS_ADDR,
    input wire [31:0] IBUS_DATA,
    input wire [15:0] X_ADDR,
    input wire [15:0] X_DATA,
    input wire [15:0] Y_ADDR,
    input wire [15:0] Y_DATA,
    input wire ADDR_MATCH,
    input wire DATA_MATCH,
    input wire BREAK_MATCH,
    input wire IRQ
);
    reg [15:0] am_u_ff, am_l_ff, dr_u_ff, dr_l_ff, dm_u_ff, dm_l_ff;
    reg [1:0] sel_ff;
    reg [2:0] st_ff, mk_ff, ev_ff;
    wire mk_wr = REG_WR && REG_ADDR == 4'h8;
    wire [31:0] ra = {REF_ADDR_UPPER_C, REF_ADDR_LOWER_C};
    // Mask bit set means ignore; X/Y address compares drop bit 0
    wire ea = !sel_ff[1] ? &((IBUS_ADDR ~^ ra) | {am_u_ff, am_l_ff}) :
        sel_ff[0] ? &((Y_ADDR ~^ ra[15:0]) | am_l_ff | 16'h0001) : &((X_ADDR ~^ ra[31:16]) | am_u_ff | 16'h0001);
    wire ed = !sel_ff[1] ? &((IBUS_DATA ~^ {dr_u_ff, dr_l_ff}) | {dm_u_ff, dm_l_ff}) :
        sel_ff[0] ? &((Y_DATA ~^ dr_l_ff) | dm_l_ff) : &((X_DATA ~^ dr_u_ff) | dm_u_ff);
    wire [2:0] ev = {ea & ed, ed, ea} & {3{BUS_CYCLE_VALID}};
    // Shadow of the six registers; manual reset keeps them
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            {am_u_ff, am_l_ff, dr_u_ff, dr_l_ff, dm_u_ff, dm_l_ff} <= 96'h0;
        end else if (REG_WR) begin
            if (REG_ADDR == 4'h0) am_u_ff <= REG_WDATA;
            if (REG_ADDR == 4'h1) am_l_ff <= REG_WDATA;
            if (REG_ADDR == 4'h2) dr_u_ff <= REG_WDATA;
            if (REG_ADDR == 4'h3) dr_l_ff <= REG_WDATA;
            if (REG_ADDR == 4'h4) dm_u_ff <= REG_WDATA;
            if (REG_ADDR == 4'h5) dm_l_ff <= REG_WDATA;
        end
    end
    // Select, status and mask clear on either reset; set beats clear
    always @(posedge CLOCK) begin
        if (!RST_N || !MRST_N) begin
            {sel_ff, st_ff, mk_ff, ev_ff} <= 11'h0;
        end else begin
            ev_ff <= ev;
            st_ff <= (st_ff & ~(REG_WR && REG_ADDR == 4'h7 ? REG_WDATA[2:0] : 3'h0)) | ev;
            if (mk_wr) mk_ff <= REG_WDATA[2:0];
            if (REG_WR && REG_ADDR == 4'h6) sel_ff <= REG_WDATA[9:8];
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    sequence s_wr_rd;
        (REG_WR && REG_ADDR < 4'h6) ##1 (REG_RD && REG_ADDR == $past(REG_ADDR));
    endsequence
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0)
        else $error("read data not zero outside a read");
    a_wr_rd_back: assert property (s_wr_rd |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("read after write lost data");
    a_addr_match: assert property (ADDR_MATCH == ev_ff[0])
        else $error("address match wrong");
    a_data_match: assert property (DATA_MATCH == ev_ff[1])
        else $error("data match wrong");
    a_break_both: assert property (BREAK_MATCH |-> ADDR_MATCH && DATA_MATCH && ev_ff[2])
        else $error("break without both matches");
    a_quiet_bus: assert property (!BUS_CYCLE_VALID |=> !ADDR_MATCH && !DATA_MATCH && !BREAK_MATCH)
        else $error("match without a bus cycle");
    a_mrst_clears: assert property (!MRST_N |=> !IRQ && !ADDR_MATCH && !BREAK_MATCH)
        else $error("manual reset left outputs set");
    a_irq_level: assert property (IRQ == |(st_ff & mk_ff))
        else $error("interrupt level wrong");
endmodule
`default_nettype wire

//--- test_bcc_break_c.sv
// Self-checking bench for the channel C compare stage.
// Assumes the bus model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module test_bcc_break_c;
    reg CLOCK = 1'b0, RST_N = 1'b0, MRST_N = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, req_v = 1'b0, req_q = 1'b0;
    reg [3:0] REG_ADDR = 4'h0;
    reg [15:0] REG_WDATA = 16'h0, REF_ADDR_UPPER_C = 16'h1234, REF_ADDR_LOWER_C = 16'h5678;
    reg [31:0] req_a = 32'h0, req_d = 32'h0;
    wire [15:0] REG_RDATA, X_ADDR, X_DATA, Y_ADDR, Y_DATA;
    wire [31:0] IBUS_ADDR, IBUS_DATA;
    wire BUS_CYCLE_VALID, ADDR_MATCH, DATA_MATCH, BREAK_MATCH, IRQ;
    integer err_total = 0, total_checks = 0, i;
    localparam [31:0] A = 32'h1234_5678, D = 32'hCAFE_BEEF;
    always #12.5 CLOCK = ~CLOCK;
    bcc_break_c dut (.CLOCK(CLOCK), .RST_N(RST_N), .MRST_N(MRST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REF_ADDR_UPPER_C(REF_ADDR_UPPER_C),
        .REF_ADDR_LOWER_C(REF_ADDR_LOWER_C), .BUS_CYCLE_VALID(BUS_CYCLE_VALID), .IBUS_ADDR(IBUS_ADDR),
        .IBUS_DATA(IBUS_DATA), .X_ADDR(X_ADDR), .X_DATA(X_DATA), .Y_ADDR(Y_ADDR), .Y_DATA(Y_DATA),
        .ADDR_MATCH(ADDR_MATCH), .DATA_MATCH(DATA_MATCH), .BREAK_MATCH(BREAK_MATCH), .IRQ(IRQ));
    bcc_bus_model bus (.clk(CLOCK), .req_v(req_v), .req_q(req_q), .req_a(req_a), .req_d(req_d),
        .valid(BUS_CYCLE_VALID),
        .ibus_a(IBUS_ADDR), .ibus_d(IBUS_DATA), .x_a(X_ADDR), .x_d(X_DATA), .y_a(Y_ADDR), .y_d(Y_DATA));
    task print_verdict;
        begin
            if (err_total == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk_reg(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Match flags packed as break, data, address
    task chk_hit(input [2:0] exp);
        begin
            chk_reg({13'h0, BREAK_MATCH, DATA_MATCH, ADDR_MATCH}, {13'h0, exp});
        end
    endtask
    // Write strobe stays up until the edge of a later rd, hit or miss task drops it
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge CLOCK);
            REG_WR <= 1'b1;
            REG_RD <= 1'b0;
            REG_ADDR <= a;
            REG_WDATA <= d;
        end
    endtask
    task rd(input [3:0] a, input [15:0] exp);
        begin
            @(posedge CLOCK);
            REG_WR <= 1'b0;
            REG_RD <= 1'b1;
            REG_ADDR <= a;
            @(posedge CLOCK);
            REG_RD <= 1'b0;
            #1 chk_reg(REG_RDATA, exp);
        end
    endtask
    task hit(input [31:0] a, input [31:0] d, input [2:0] exp);
        begin
            @(posedge CLOCK);
            REG_WR <= 1'b0;
            req_v <= 1'b1;
            req_a <= a;
            req_d <= d;
            @(posedge CLOCK);
            req_v <= 1'b0;
            #1 chk_hit(exp);
        end
    endtask
    // Matching buses shown without a qualifying cycle must not match
    task miss(input [31:0] a, input [31:0] d);
        begin
            @(posedge CLOCK);
            REG_WR <= 1'b0;
            req_q <= 1'b1;
            req_a <= a;
            req_d <= d;
            @(posedge CLOCK);
            req_q <= 1'b0;
            #1 chk_hit(3'h0);
        end
    endtask
    task setup(input [15:0] amu, input [15:0] aml, input [15:0] dmu, input [15:0] dml, input [15:0] sl);
        begin
            wr(4'h0, amu);
            wr(4'h1, aml);
            wr(4'h2, D[31:16]);
            wr(4'h3, D[15:0]);
            wr(4'h4, dmu);
            wr(4'h5, dml);
            wr(4'h6, sl);
        end
    endtask
    // Hang guard: the sequence needs about 140 cycles
    initial begin
        repeat (3000) @(posedge CLOCK);
        err_total = err_total + 1;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        for (i = 0; i < 6; i = i + 1) rd(i[3:0], 16'h0);
        for (i = 0; i < 6; i = i + 1) begin
            wr(i[3:0], {12'hA5C, i[3:0]});
            rd(i[3:0], {12'hA5C, i[3:0]});
        end
        rd(4'h9, 16'h0);
        setup(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        hit(A, D, 3'h7);
        hit(32'h1224_5678, D, 3'h2);
        hit(32'h1234_5679, D, 3'h2);
        hit(A, 32'hCAFF_BEEF, 3'h1);
        hit(A, 32'hCAFE_BEE7, 3'h1);
        setup(16'h0010, 16'h0001, 16'h0001, 16'h0008, 16'h0);
        hit(32'h1224_5679, 32'hCAFF_BEE7, 3'h7);
        hit(A, 32'hCAFE_BEEB, 3'h1);
        setup(16'h0100, 16'hFFFF, 16'h0, 16'hFFFF, 16'h0200);
        hit(32'h1335_0000, 32'hCAFE_0000, 3'h7);
        hit(32'h1234_5678, 32'hCAEE_BEEF, 3'h1);
        setup(16'h0, 16'h0, 16'h0, 16'h0, 16'h0300);
        hit(32'h0000_5679, 32'h0000_BEEF, 3'h7);
        hit(32'h1234_5478, D, 3'h2);
        setup(16'h0, 16'h0, 16'h0, 16'h0, 16'h0100);
        hit(32'h1234_5679, D, 3'h2);
        hit(A, D, 3'h7);
        miss(A, D);
        setup(16'h0, 16'h0, 16'hFFFF, 16'hFF00, 16'h0);
        hit(32'h1234_5678, 32'h0000_00EF, 3'h7);
        hit(32'h1234_5678, 32'h0000_00EE, 3'h1);
        wr(4'h7, 16'h0007);
        wr(4'h8, 16'h0007);
        rd(4'h7, 16'h0000);
        chk_reg({15'h0, IRQ}, 16'h0000);
        hit(A, D, 3'h7);
        rd(4'h7, 16'h0007);
        chk_reg({15'h0, IRQ}, 16'h0001);
        wr(4'h8, 16'h0000);
        wr(4'h7, 16'h0001);
        rd(4'h7, 16'h0006);
        chk_reg({15'h0, IRQ}, 16'h0000);
        wr(4'h8, 16'h0004);
        wr(4'h5, 16'hFFFF);
        rd(4'h5, 16'hFFFF);
        chk_reg({15'h0, IRQ}, 16'h0001);
        @(posedge CLOCK);
        MRST_N <= 1'b0;
        @(posedge CLOCK);
        MRST_N <= 1'b1;
        rd(4'h7, 16'h0000);
        rd(4'h6, 16'h0000);
        chk_reg({15'h0, IRQ}, 16'h0000);
        @(posedge CLOCK);
        RST_N <= 1'b0;
        @(posedge CLOCK);
        RST_N <= 1'b1;
        rd(4'h5, 16'h0000);
        print_verdict;
    end
endmodule
bind bcc_break_c bcc_break_c_asserts chk (.CLOCK(CLOCK), .RST_N(RST_N), .MRST_N(MRST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REF_ADDR_UPPER_C(REF_ADDR_UPPER_C), .REF_ADDR_LOWER_C(REF_ADDR_LOWER_C), .BUS_CYCLE_VALID(BUS_CYCLE_VALID),
    .IBUS_ADDR(IBUS_ADDR), .IBUS_DATA(IBUS_DATA), .X_ADDR(X_ADDR), .X_DATA(X_DATA), .Y_ADDR(Y_ADDR),
    .Y_DATA(Y_DATA), .ADDR_MATCH(ADDR_MATCH), .DATA_MATCH(DATA_MATCH), .BREAK_MATCH(BREAK_MATCH), .IRQ(IRQ));
`default_nettype wire
